// *** fault_defs.svh ***
// fault_defs.svh: shared constants of the output fault logic
// assumes inclusion by bare name; holds defines only
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define MCLK_FREQ_MHZ   50
`define BLANK_TIME_US   160
`define SHUT_TIME_US    20

// ---------------------------------------------------------------
// channel and word layout
// ---------------------------------------------------------------
`define NUM_OUTPUTS     8
`define CMD_OFF_BIT     1'b1
`define STAT_OFF_BIT    1'b1
`define STAT_OPEN_BIT   1'b0

// ---------------------------------------------------------------
// positions in the synchroniser vector
// ---------------------------------------------------------------
`define SYN_CS          0
`define SYN_SCLK        1
`define SYN_SI          2
`define SYN_POLICY      3
`define SYN_OV          4
`define SYN_UV          5
`define SYN_SENSE_BASE  6

`endif

// *** fault_pkg.sv ***
// fault_pkg.sv: types of the output fault logic
// assumes nothing beyond a SystemVerilog compiler
package fault_pkg;

  // ---------------------------------------------------------------
  // serial link state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_FRAME = 1'b1
  } link_state_e;

endpackage

// *** output_short_fault_logic.sv ***
// output_short_fault_logic.sv: per-output short, thermal and supply fault logic
// assumes pins are asynchronous to mclk_i and sense inputs come from comparators
//
// Function
// - grounded policy: chip select rise turns on new outputs, starts blanking timer
// - grounded policy: short before or during blanking shuts the output off at timer expiry
// - short after blanking under grounded policy shuts output within 20 us
// - high policy never disables on over-current; output stays current limited
// - thermal and over-voltage shutdown ignore the policy level
// - each output owns independent over-current shutdown state
// - one policy level governs all eight outputs together
// - high policy: output recovers by itself when short goes, unless thermal
// - grounded policy: latched-off output stays off until the next write
// - grounded policy, persistent short: each on-write gives blanking time on, then off
// - thermal limit latches only that output off
// - logic undervoltage turns all outputs off and status reads all off
// - load supply undervoltage neither turns outputs off nor resets logic
// - healthy status bit equals previous command bit; host flags mismatch
// - commanded off with open load returns a low status bit
// - commanded on with over-current returns a high status bit
// - over-current reported under either policy, also while limiting
// - load supply over-voltage latches all outputs off until new word
// - chip select fall enables serial out and loads status bits
// - chip select rise moves shifted word to switches, low means on
// - first write after over-voltage returns all ones
`include "fault_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module output_short_fault_logic #(
  parameter int NUM_OUT      = `NUM_OUTPUTS,
  parameter int BLANK_CYCLES = `BLANK_TIME_US * `MCLK_FREQ_MHZ
) (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  // serial link
  input  wire logic               cs_b_i,
  input  wire logic               sclk_i,
  input  wire logic               si_i,
  output logic                    so_o,
  output logic                    so_oe_o,
  // policy and supplies
  input  wire logic               short_shutdown_policy_i,
  input  wire logic               load_supply_ov_i,
  input  wire logic               logic_supply_uv_i,
  // per-output sensing
  input  wire logic [NUM_OUT-1:0] short_sense_i,
  input  wire logic [NUM_OUT-1:0] open_sense_i,
  input  wire logic [NUM_OUT-1:0] therm_limit_i,
  // switch drive
  output logic      [NUM_OUT-1:0] gate_on_o,
  output logic      [NUM_OUT-1:0] current_limited_o
);

  import fault_pkg::*;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam int SW         = `SYN_SENSE_BASE + 3 * NUM_OUT;
  localparam int CW         = $clog2(BLANK_CYCLES + 1);
  localparam int SHUT_LAT   = 2;
  localparam logic [CW-1:0] BLANK_LOAD = CW'(BLANK_CYCLES);
  localparam logic [NUM_OUT-1:0] ALL_OFF = {NUM_OUT{`CMD_OFF_BIT}};

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [SW-1:0]      sync_in;
  logic [SW-1:0]      sync_lvl;
  logic               cs_s;
  logic               sclk_s;
  logic               si_s;
  logic               policy_s;
  logic               ov_s;
  logic               uv_s;
  logic [NUM_OUT-1:0] short_s;
  logic [NUM_OUT-1:0] open_s;
  logic [NUM_OUT-1:0] therm_s;

  assign sync_in = {therm_limit_i, open_sense_i, short_sense_i, logic_supply_uv_i,
                    load_supply_ov_i, short_shutdown_policy_i, si_i, sclk_i, cs_b_i};

  pin_sync #(.WIDTH(SW)) u_sync (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (sync_in),
    .level_o (sync_lvl)
  );

  assign cs_s     = sync_lvl[`SYN_CS];
  assign sclk_s   = sync_lvl[`SYN_SCLK];
  assign si_s     = sync_lvl[`SYN_SI];
  assign policy_s = sync_lvl[`SYN_POLICY];
  assign ov_s     = sync_lvl[`SYN_OV];
  assign uv_s     = sync_lvl[`SYN_UV];
  assign short_s  = sync_lvl[`SYN_SENSE_BASE +: NUM_OUT];
  assign open_s   = sync_lvl[`SYN_SENSE_BASE + NUM_OUT +: NUM_OUT];
  assign therm_s  = sync_lvl[`SYN_SENSE_BASE + 2 * NUM_OUT +: NUM_OUT];

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic cs_prev_reg;
  logic sclk_prev_reg;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_prev_reg   <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg   <= cs_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  assign cs_fall   = cs_prev_reg & ~cs_s;
  assign cs_rise   = ~cs_prev_reg & cs_s;
  assign sclk_rise = ~sclk_prev_reg & sclk_s;
  assign sclk_fall = sclk_prev_reg & ~sclk_s;

  // ---------------------------------------------------------------
  // link state
  // ---------------------------------------------------------------
  link_state_e link_state_reg;
  logic        frame_start;
  logic        write_pulse;

  // a frame cut short by logic undervoltage is dropped
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_state_reg <= LINK_IDLE;
    end else if (uv_s) begin
      link_state_reg <= LINK_IDLE;
    end else begin
      case (link_state_reg)
        LINK_IDLE:  if (cs_fall) link_state_reg <= LINK_FRAME;
        LINK_FRAME: if (cs_rise) link_state_reg <= LINK_IDLE;
        default:    link_state_reg <= LINK_IDLE;
      endcase
    end
  end

  assign frame_start = cs_fall & (link_state_reg == LINK_IDLE) & ~uv_s;
  assign write_pulse = cs_rise & (link_state_reg == LINK_FRAME) & ~uv_s;
  assign so_oe_o     = (link_state_reg == LINK_FRAME);

  // ---------------------------------------------------------------
  // shift registers and command word
  // ---------------------------------------------------------------
  logic [NUM_OUT-1:0] in_shift_reg;
  logic [NUM_OUT-1:0] out_shift_reg;
  logic [NUM_OUT-1:0] cmd_reg;
  logic [NUM_OUT-1:0] status_word;
  logic               first_rise_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_shift_reg <= ALL_OFF;
    end else if (frame_start) begin
      in_shift_reg <= ALL_OFF;
    end else if ((link_state_reg == LINK_FRAME) && sclk_fall) begin
      in_shift_reg <= {in_shift_reg[NUM_OUT-2:0], si_s};
    end
  end

  // the first rising clock follows the status load, so it must not shift
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_shift_reg  <= ALL_OFF;
      first_rise_reg <= 1'b0;
    end else if (frame_start) begin
      out_shift_reg  <= status_word;
      first_rise_reg <= 1'b1;
    end else if ((link_state_reg == LINK_FRAME) && sclk_rise) begin
      first_rise_reg <= 1'b0;
      if (!first_rise_reg) begin
        out_shift_reg <= {out_shift_reg[NUM_OUT-2:0], 1'b0};
      end
    end
  end

  assign so_o = out_shift_reg[NUM_OUT-1];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_reg <= ALL_OFF;
    end else if (uv_s) begin
      cmd_reg <= ALL_OFF;
    end else if (write_pulse) begin
      cmd_reg <= in_shift_reg;
    end
  end

  // ---------------------------------------------------------------
  // global over-voltage
  // ---------------------------------------------------------------
  logic ov_latch_reg;
  logic ov_report_reg;

  // set wins over the clear in both flags
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov_latch_reg <= 1'b0;
    end else if (ov_s) begin
      ov_latch_reg <= 1'b1;
    end else if (write_pulse || uv_s) begin
      ov_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov_report_reg <= 1'b0;
    end else if (ov_s) begin
      ov_report_reg <= 1'b1;
    end else if (frame_start || uv_s) begin
      ov_report_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status encoding
  // ---------------------------------------------------------------
  function automatic logic status_bit(input logic cmd_off, input logic fault_on,
                                      input logic open_off);
    logic res;
    res = cmd_off;
    if (!cmd_off && fault_on) begin
      res = `STAT_OFF_BIT;
    end else if (cmd_off && open_off) begin
      res = `STAT_OPEN_BIT;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // per-output channels
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_ch
      logic [CW-1:0] blank_cnt_reg;
      logic          oc_latch_reg;
      logic          therm_latch_reg;
      logic          oc_seen_reg;
      logic          gate_reg;
      logic          limit_reg;
      logic          cmd_on;
      logic          blanking;
      logic          oc_set;
      logic          fault_on;

      assign cmd_on   = (cmd_reg[gi] != `CMD_OFF_BIT);
      assign blanking = (blank_cnt_reg != '0);
      // a write that turns the output on restarts blanking, so a set in that cycle is deferred to expiry
      assign oc_set   = ~policy_s & short_s[gi] & cmd_on & ~blanking & ~write_pulse;

      // restarted on every write that turns an off or latched output on
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          blank_cnt_reg <= '0;
        end else if (uv_s) begin
          blank_cnt_reg <= '0;
        end else if (write_pulse) begin
          if ((in_shift_reg[gi] != `CMD_OFF_BIT) && !gate_reg) begin
            blank_cnt_reg <= BLANK_LOAD;
          end else if (in_shift_reg[gi] == `CMD_OFF_BIT) begin
            blank_cnt_reg <= '0;
          end
        end else if (blanking) begin
          blank_cnt_reg <= blank_cnt_reg - CW'(1);
        end
      end

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          oc_latch_reg <= 1'b0;
        end else if (uv_s) begin
          oc_latch_reg <= 1'b0;
        end else if (oc_set) begin
          oc_latch_reg <= 1'b1;
        end else if (write_pulse) begin
          oc_latch_reg <= 1'b0;
        end
      end

      // thermal shutdown is policy independent
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          therm_latch_reg <= 1'b0;
        end else if (therm_s[gi]) begin
          therm_latch_reg <= 1'b1;
        end else if (write_pulse || uv_s) begin
          therm_latch_reg <= 1'b0;
        end
      end

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          oc_seen_reg <= 1'b0;
        end else if (short_s[gi] && gate_reg) begin
          oc_seen_reg <= 1'b1;
        end else if (frame_start || uv_s) begin
          oc_seen_reg <= 1'b0;
        end
      end

      // no load supply undervoltage term: outputs follow the command word
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          gate_reg  <= 1'b0;
          limit_reg <= 1'b0;
        end else begin
          gate_reg  <= cmd_on & ~oc_latch_reg & ~therm_latch_reg
                       & ~ov_latch_reg & ~ov_s & ~uv_s;
          limit_reg <= gate_reg & short_s[gi] & policy_s;
        end
      end

      assign fault_on          = oc_seen_reg | oc_latch_reg | therm_latch_reg
                                 | (short_s[gi] & gate_reg);
      assign status_word[gi]   = (ov_report_reg | uv_s) ? `STAT_OFF_BIT :
                                 status_bit(~cmd_on, fault_on, open_s[gi]);
      assign gate_on_o[gi]         = gate_reg;
      assign current_limited_o[gi] = limit_reg;

      // -------------------------------------------------------------
      // channel checks
      // -------------------------------------------------------------
      AST_BLANK_START: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        (write_pulse && (in_shift_reg[gi] == 1'b0) && !gate_reg)
          |=> (blank_cnt_reg == BLANK_LOAD))
        else $error("blanking timer not started on turn-on");

      AST_LATCH_AFTER_BLANK: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        $rose(oc_latch_reg) |-> ($past(blank_cnt_reg) == '0) && !$past(policy_s))
        else $error("over-current latch set while blanking or under high policy");

      AST_FAST_SHUT: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        oc_set |-> ##[1:SHUT_LAT] !gate_reg)
        else $error("short after blanking did not shut the output");

      AST_NO_LATCH_HIGH: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        policy_s |=> !$rose(oc_latch_reg))
        else $error("output latched under high policy");

      AST_LATCH_HOLDS: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        (oc_latch_reg && !write_pulse && !uv_s) |=> oc_latch_reg ##1 !gate_reg)
        else $error("latched output released without a write");

      AST_THERM_OFF: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        therm_s[gi] |-> ##[1:SHUT_LAT] !gate_reg)
        else $error("thermal limit did not turn the output off");
    end
  endgenerate

  // ---------------------------------------------------------------
  // global checks
  // ---------------------------------------------------------------
  sequence s_write;
    write_pulse && !uv_s;
  endsequence

  // a still-present over-voltage keeps the report armed for the next frame
  sequence s_ov_then_frame;
    ov_report_reg && frame_start && !ov_s;
  endsequence

  AST_WRITE_LOADS: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    s_write |=> (cmd_reg == $past(in_shift_reg)))
    else $error("command word not transferred on chip select rise");

  AST_STATUS_LOAD: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    frame_start |=> so_oe_o && (out_shift_reg == $past(status_word)))
    else $error("status not loaded on chip select fall");

  AST_OV_ALL_ONES: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    s_ov_then_frame |=> (out_shift_reg == ALL_OFF) && !ov_report_reg)
    else $error("first frame after over-voltage not all ones");

  AST_OV_OFF: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ov_s |-> ##[1:SHUT_LAT] (gate_on_o == '0))
    else $error("over-voltage did not turn all outputs off");

  AST_UV_OFF: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    uv_s |=> (gate_on_o == '0) && (cmd_reg == ALL_OFF))
    else $error("logic undervoltage did not clear outputs");

  AST_OC_REPORTED: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    frame_start |=> ((out_shift_reg & $past(short_s & gate_on_o))
                     == $past(short_s & gate_on_o)))
    else $error("live over-current missing from the status word");

endmodule // output_short_fault_logic

`default_nettype wire

// *** pin_sync.sv ***
// pin_sync.sv: three-stage synchroniser with agreement filter
// assumes pins are asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] mid_reg;
  logic [WIDTH-1:0] late_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      mid_reg  <= '0;
      late_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      mid_reg  <= meta_reg;
      late_reg <= mid_reg;
    end
  end

  // a bit moves only once the second and third stage agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= '0;
    end else begin
      level_o <= (mid_reg & late_reg) | (level_o & (mid_reg ^ late_reg));
    end
  end

endmodule // pin_sync

`default_nettype wire

// *** spi_host_model.sv ***
// spi_host_model.sv: host side of the serial link, msb first
// assumes mclk_i is the device clock; link edges are paced from it
`timescale 1ns/10ps
`default_nettype none

module spi_host_model #(
  parameter int HALF = 4
) (
  // clock
  input  wire logic mclk_i,
  // serial link
  output var logic  cs_b_o,
  output var logic  sclk_o,
  output var logic  si_o,
  input  wire logic so_i
);
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end

  // ------------------------------
  // one frame
  // ------------------------------
  // 160 ns link period; the device sees each edge some clocks late, so read at bit end
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] stat);
    @(posedge mclk_i) cs_b_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    for (int i = 7; i >= 0; i--) begin
      sclk_o <= 1'b1;
      si_o   <= cmd[i];
      repeat (HALF) @(posedge mclk_i);
      sclk_o <= 1'b0;
      repeat (HALF) @(posedge mclk_i);
      stat[i] = so_i;
    end
    cs_b_o <= 1'b1;
    repeat (12) @(posedge mclk_i);
    // released data line flips so a stale bit never looks valid
    si_o <= ~si_o;
  endtask
endmodule // spi_host_model

`default_nettype wire

// *** tb_output_short_fault_logic.sv ***
// tb_output_short_fault_logic.sv: self-checking bench of the fault logic
// assumes spi_host_model drives the link; sense pins are driven here
`timescale 1ns/10ps
`default_nettype none

module tb_output_short_fault_logic;
  localparam int BLANK = 20;
  logic       mclk_i  = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       policy  = 1'b0;
  logic       ov      = 1'b0;
  logic       uv      = 1'b0;
  logic [7:0] short_s = '0;
  logic [7:0] open_s  = '0;
  logic [7:0] therm   = '0;
  logic [7:0] gate;
  logic [7:0] climit;
  logic [7:0] stat;
  logic [7:0] w;
  logic       cs_b;
  logic       sclk;
  logic       si;
  logic       so;
  logic       so_oe;
  logic [7:0] cmd_q[$];
  int         fail_count  = 0;
  int         checks_done = 0;

  always #10 mclk_i = ~mclk_i;

  output_short_fault_logic #(.NUM_OUT(8), .BLANK_CYCLES(BLANK)) output_short_fault_logic_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .short_shutdown_policy_i(policy),
    .load_supply_ov_i(ov), .logic_supply_uv_i(uv), .short_sense_i(short_s),
    .open_sense_i(open_s), .therm_limit_i(therm), .gate_on_o(gate),
    .current_limited_o(climit));

  spi_host_model spi_host_model_inst (
    .mclk_i(mclk_i), .cs_b_o(cs_b), .sclk_o(sclk), .si_o(si), .so_i(so));

  // ------------------------------
  // checking and closing
  // ------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // model: status is last command, faults force ones, open loads force zeros
  task automatic frame(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo);
    spi_host_model_inst.xfer(cmd, stat);
    check(stat, (cmd_q[$] | hi) & ~lo);
    cmd_q.push_back(cmd);
  endtask

  task automatic wait_gate(input int ch, input logic v, input int n);
    int k;
    for (k = 0; k < n && gate[ch] !== v; k++)
      @(posedge mclk_i);
    if (k == n) begin
      fail_count++;
      close_out();
    end
    check(8'(gate[ch]), 8'(v));
  endtask

  initial begin
    #2_000_000;
    fail_count++;
    close_out();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    void'($urandom(18746));
    cmd_q.push_back(8'hFF);
    repeat (20) @(posedge mclk_i);
    check(gate, 8'h00);
    check(8'(so_oe), 8'h00);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    for (int n = 0; n < 3; n++) begin
      w = 8'($urandom);
      frame(w, 8'h00, 8'h00);
      check(gate, ~w);
    end
    $display("test healthy done");
    frame(8'hFF, 8'h00, 8'h00);
    open_s <= 8'h0F;
    repeat (10) @(posedge mclk_i);
    frame(8'hFF, 8'h00, 8'h0F);
    open_s <= 8'h00;
    $display("test open load done");
    short_s <= 8'h01;
    frame(8'hFC, 8'h00, 8'h00);
    check(gate, 8'h03);
    wait_gate(0, 1'b0, BLANK + 10);
    check(gate, 8'h02);
    short_s <= 8'h00;
    repeat (BLANK * 2) @(posedge mclk_i);
    check(gate, 8'h02);
    short_s <= 8'h01;
    frame(8'hFC, 8'h01, 8'h00);
    check(gate, 8'h03);
    wait_gate(0, 1'b0, BLANK + 10);
    short_s <= 8'h00;
    frame(8'hFC, 8'h01, 8'h00);
    repeat (BLANK * 2) @(posedge mclk_i);
    check(gate, 8'h03);
    short_s <= 8'h02;
    wait_gate(1, 1'b0, 1000);
    check(gate, 8'h01);
    short_s <= 8'h00;
    frame(8'hFC, 8'h02, 8'h00);
    check(gate, 8'h03);
    $display("test latched shutdown done");
    policy  <= 1'b1;
    short_s <= 8'h03;
    repeat (BLANK * 3) @(posedge mclk_i);
    check(gate, 8'h03);
    check(climit, 8'h03);
    frame(8'hFC, 8'h03, 8'h00);
    short_s <= 8'h00;
    repeat (10) @(posedge mclk_i);
    check(climit, 8'h00);
    check(gate, 8'h03);
    therm <= 8'h02;
    wait_gate(1, 1'b0, 20);
    check(gate, 8'h01);
    therm <= 8'h00;
    repeat (10) @(posedge mclk_i);
    check(gate, 8'h01);
    frame(8'hFC, 8'h03, 8'h00);
    check(gate, 8'h03);
    policy <= 1'b0;
    $display("test current limit and thermal done");
    ov <= 1'b1;
    repeat (10) @(posedge mclk_i);
    check(gate, 8'h00);
    ov <= 1'b0;
    repeat (10) @(posedge mclk_i);
    check(gate, 8'h00);
    frame(8'hFC, 8'hFF, 8'h00);
    check(gate, 8'h03);
    uv <= 1'b1;
    repeat (10) @(posedge mclk_i);
    check(gate, 8'h00);
    uv <= 1'b0;
    cmd_q.push_back(8'hFF);
    repeat (10) @(posedge mclk_i);
    frame(8'hFC, 8'hFF, 8'h00);
    check(gate, 8'h03);
    $display("test supply faults done");
    close_out();
  end
endmodule // tb_output_short_fault_logic

`default_nettype wire
